// file: tb_top.sv
`timescale 1ns/100ps
`include "tbsfc_cfg.svh"
module tb_top;
  import tbsfc_pkg::*;
  // short counts keep the hiccup and overload runs brief
  localparam int DIV = 16;
  localparam int OCW = 4;
  localparam int HIC = 16;
  logic        aclk, aresetn;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        seq_select, enable_first, enable_second, enable_third;
  logic        over_temp, undervoltage_lockout;
  logic        power_ok_out, power_ok_oe, irq;
  tbsfc_chan_t overvoltage_guard, boot_node_low, peak_current, source_limit;
  tbsfc_chan_t sink_limit, zero_current, comp_low, overload, drift_out;
  tbsfc_chan_t feedback_in_window, feedback_out_window, soft_start_active;
  tbsfc_chan_t high_side_on, low_side_on;
  int          failures, checked, t0, t1;

  tbsfc_ctrl #(.SW_DIV(DIV), .OC_WAIT(OCW), .HICCUP(HIC)) i_dut (.*);
  tbsfc_stage_model #(.SETTLE(40)) i_stage (.*);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    failures++;
    $display("FAIL %0t no answer for %s", $time, what);
    end_of_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask

  // the running field is polled, so each stage must last a few reads
  task automatic poll_run(input logic [2:0] m);
    repeat (400) begin
      rd_reg(`TBSFC_ADDR_STATUS);
      if (rd[5:3] === m) begin
        checked++;
        return;
      end
    end
    hang("channel state");
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {seq_select, enable_first, enable_second, enable_third} = 4'h0;
    {over_temp, undervoltage_lockout, aresetn} = 3'h0;
    {overvoltage_guard, boot_node_low, peak_current} = 9'h000;
    {source_limit, sink_limit, zero_current} = 9'h000;
    {comp_low, overload, drift_out} = 9'h000;
    failures = 0;
    checked = 0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(1);
    chk(power_ok_oe, 1'b1);
    chk(high_side_on | low_side_on, 3'h0);
    chk(irq, 1'b0);
    rd_reg(`TBSFC_ADDR_CTRL);
    chk(rd, `TBSFC_CTRL_RESET);
    chk(rsp, `TBSFC_RESP_OKAY);
    rd_reg(`TBSFC_ADDR_IRQ_MASK);
    chk(rd, `TBSFC_IRQ_MASK_RST);
    rd_reg(4'h2);
    chk(rsp, `TBSFC_RESP_SLVERR);
    wr(`TBSFC_ADDR_IRQ_MASK, 32'h0000_000F);
    chk(rsp, `TBSFC_RESP_OKAY);
    wr(4'h1, 32'h0000_0000);
    chk(rsp, `TBSFC_RESP_SLVERR);
    enable_first <= 1'b1;
    poll_run(3'b001);
    chk(power_ok_oe, 1'b1);
    enable_second <= 1'b1;
    enable_third <= 1'b1;
    poll_run(3'b111);
    cyc(60);
    chk(power_ok_oe, 1'b0);
    chk(power_ok_out, 1'b0);
    drift_out <= 3'b010;
    cyc(6);
    chk(power_ok_oe, 1'b1);
    chk(irq, 1'b1);
    rd_reg(`TBSFC_ADDR_IRQ_STAT);
    chk(rd[`TBSFC_IRQ_PWR_LOST], 1'b1);
    cyc(3);
    chk(irq, 1'b0);
    drift_out <= 3'b000;
    cyc(60);
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: peak_current <= 3'b010;
        1: overvoltage_guard <= 3'b010;
        2: boot_node_low <= 3'b010;
        3: sink_limit <= 3'b010;
        default: source_limit <= 3'b010;
      endcase
      cyc(k == 4 ? DIV + 4 : 4);
      chk(high_side_on[1], 1'b0);
      chk(low_side_on[1], k != 3);
      {peak_current, overvoltage_guard, boot_node_low} <= 9'h000;
      {sink_limit, source_limit} <= 6'h00;
      cyc(DIV + 4);
      chk(high_side_on[1], 1'b1);
    end
    peak_current <= 3'b011;
    cyc(4);
    peak_current <= 3'b000;
    t0 = -1;
    t1 = -1;
    for (int n = 0; n < 2 * DIV; n++) begin
      @(posedge aclk);
      if (t0 < 0 && high_side_on[0] === 1'b1) t0 = n;
      if (t1 < 0 && high_side_on[1] === 1'b1) t1 = n;
    end
    chk((t0 - t1 + DIV) % DIV, DIV / 2);
    overload <= 3'b001;
    cyc((OCW - 1) * DIV);
    chk(high_side_on[0], 1'b1);
    cyc(4 * DIV);
    overload <= 3'b000;
    chk(high_side_on[0] | low_side_on[0], 1'b0);
    rd_reg(`TBSFC_ADDR_IRQ_STAT);
    chk(rd[`TBSFC_IRQ_HICCUP], 1'b1);
    cyc((HIC / 2) * DIV);
    chk(high_side_on[0] | low_side_on[0], 1'b0);
    cyc((HIC / 2 + 2) * DIV);
    rd_reg(`TBSFC_ADDR_STATUS);
    chk(rd[8:3], 6'b000_111);
    peak_current <= 3'b100;
    cyc(4);
    chk(low_side_on[2], 1'b1);
    zero_current <= 3'b100;
    cyc(4);
    chk(low_side_on[2], 1'b0);
    {peak_current, zero_current} <= 6'h00;
    comp_low <= 3'b100;
    cyc(DIV + 4);
    chk(high_side_on[2] | low_side_on[2], 1'b0);
    wr(`TBSFC_ADDR_CTRL, 32'h0000_0000);
    cyc(DIV + 4);
    chk(high_side_on[2], 1'b1);
    comp_low <= 3'b000;
    wr(`TBSFC_ADDR_CTRL, 32'h0000_0001);
    wr(`TBSFC_ADDR_IRQ_MASK, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      cyc(60);
      if (k == 0) over_temp <= 1'b1;
      else undervoltage_lockout <= 1'b1;
      cyc(6);
      chk(high_side_on | low_side_on, 3'h0);
      chk(power_ok_oe, 1'b1);
      chk(irq, k == 0);
      rd_reg(`TBSFC_ADDR_IRQ_STAT);
      chk(rd[k + 1], 1'b1);
      {over_temp, undervoltage_lockout} <= 2'h0;
      poll_run(3'b111);
    end
    {enable_first, enable_second, enable_third} <= 3'h0;
    poll_run(3'b000);
    seq_select <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      enable_first <= (m != 0);
      enable_second <= (m != 1);
      enable_third <= 1'b1;
      poll_run(m == 2 ? 3'b100 : 3'b010);
      poll_run(m == 0 ? 3'b011 : 3'b110);
      poll_run(3'b111);
      enable_third <= 1'b0;
      poll_run(m == 0 ? 3'b011 : 3'b110);
      poll_run(m == 2 ? 3'b100 : 3'b010);
      poll_run(3'b000);
      chk(power_ok_oe, 1'b1);
    end
    // both order enables low is reserved: nothing may start
    {enable_first, enable_second, enable_third} <= 3'b001;
    cyc(40);
    rd_reg(`TBSFC_ADDR_STATUS);
    chk(rd[5:3], 3'b000);
    end_of_test();
  end
endmodule

// file: tbsfc_cfg.svh
`ifndef TBSFC_CFG_SVH
`define TBSFC_CFG_SVH

// register byte offsets
`define TBSFC_ADDR_CTRL     4'h0
`define TBSFC_ADDR_STATUS   4'h4
`define TBSFC_ADDR_IRQ_STAT 4'h8
`define TBSFC_ADDR_IRQ_MASK 4'hC

// control register fields and reset value
`define TBSFC_CTRL_SKIP_BIT 0
`define TBSFC_CTRL_RESET    1'h1

// interrupt status bit positions
`define TBSFC_IRQ_HICCUP    0
`define TBSFC_IRQ_THERMAL   1
`define TBSFC_IRQ_UNDERVOLTAGE_LOCKOUT      2
`define TBSFC_IRQ_PWR_LOST  3
`define TBSFC_IRQ_W         4
`define TBSFC_IRQ_MASK_RST  4'h0

// timing counts in switching cycles, and aclk cycles per switching cycle
`define TBSFC_OC_WAIT       256
`define TBSFC_HICCUP        8192
`define TBSFC_SW_DIV        333

// answers
`define TBSFC_RESP_OKAY     2'h0
`define TBSFC_RESP_SLVERR   2'h2

`endif

// file: tbsfc_ctrl.sv
`timescale 1ns/100ps
`include "tbsfc_cfg.svh"

// Summary of operation
// - sequencing-select high: enable one/two set order, three runs it
// - orders: 2,1,3 up / 3,1,2 down, 2,3,1 up / 1,3,2 down, or 3,2,1 up / 1,2,3 down
// - sequencing-select low: each enable drives its own channel directly
// - channel one switches half a period after channels two and three
// - overvoltage holds high side off; it returns at next cycle start
// - full duty allowed; boot undervoltage forces high off, low on
// - peak-current trip turns the high side off within the cycle
// - sourcing limit at cycle boundary skips high side, keeps low on
// - sinking limit: low side off at once, both off until next cycle
// - overload beyond 256 cycles shuts channel down for 8192 cycles
// - power-ok released only when all feedbacks sit inside window
// - power-ok pulled low when any feedback leaves outer window
// - power-ok low in lockout, thermal stop, enable low, soft start
// - over-temperature stops switching; sequence reruns once it clears
// - input undervoltage forces all converters off
// - skip mode: zero-current trip turns the low side off
// - skip mode: low compensation suspends switching until it rises
module tbsfc_ctrl #(
  parameter int SW_DIV  = `TBSFC_SW_DIV,
  parameter int OC_WAIT = `TBSFC_OC_WAIT,
  parameter int HICCUP  = `TBSFC_HICCUP
) (
  // clock and reset
  input  logic               aclk,
  input  logic               aresetn,
  // axi4-lite slave
  input  logic               s_axi_awvalid,
  output logic               s_axi_awready,
  input  logic [3:0]         s_axi_awaddr,
  input  logic               s_axi_wvalid,
  output logic               s_axi_wready,
  input  logic [31:0]        s_axi_wdata,
  input  logic [3:0]         s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  logic               s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  logic               s_axi_arvalid,
  output logic               s_axi_arready,
  input  logic [3:0]         s_axi_araddr,
  output logic               s_axi_rvalid,
  input  logic               s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  // sequencing pins
  input  logic               seq_select,
  input  logic               enable_first,
  input  logic               enable_second,
  input  logic               enable_third,
  // per-channel comparators, bit 0 is channel_one
  input  tbsfc_pkg::tbsfc_chan_t overvoltage_guard,
  input  tbsfc_pkg::tbsfc_chan_t boot_node_low,
  input  tbsfc_pkg::tbsfc_chan_t peak_current,
  input  tbsfc_pkg::tbsfc_chan_t source_limit,
  input  tbsfc_pkg::tbsfc_chan_t sink_limit,
  input  tbsfc_pkg::tbsfc_chan_t zero_current,
  input  tbsfc_pkg::tbsfc_chan_t comp_low,
  input  tbsfc_pkg::tbsfc_chan_t overload,
  input  tbsfc_pkg::tbsfc_chan_t feedback_in_window,
  input  tbsfc_pkg::tbsfc_chan_t feedback_out_window,
  input  tbsfc_pkg::tbsfc_chan_t soft_start_active,
  // chip-level comparators
  input  logic               over_temp,
  input  logic               undervoltage_lockout,
  // power stage drive
  output tbsfc_pkg::tbsfc_chan_t high_side_on,
  output tbsfc_pkg::tbsfc_chan_t low_side_on,
  // open-drain power_ok_output
  output logic               power_ok_out,
  output logic               power_ok_oe,
  // interrupt
  output logic               irq
);
  import tbsfc_pkg::*;

  localparam int IN_W = 39;

  // every sequencing and comparator pin passes two flops before use
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {seq_select, enable_first, enable_second, enable_third,
                over_temp, undervoltage_lockout, overvoltage_guard,
                boot_node_low, peak_current, source_limit, sink_limit,
                zero_current, comp_low, overload, feedback_in_window,
                feedback_out_window, soft_start_active};
      sync2 <= sync1;
    end
  end

  logic s_mode, s_en1, s_en2, s_en3, s_ot, s_undervoltage_lockout;
  tbsfc_chan_t s_ov, s_buv, s_peak, s_src, s_sink, s_zc, s_cl, s_ovl;
  tbsfc_chan_t s_pgin, s_oow, s_ss;
  assign {s_mode, s_en1, s_en2, s_en3, s_ot, s_undervoltage_lockout, s_ov, s_buv, s_peak,
          s_src, s_sink, s_zc, s_cl, s_ovl, s_pgin, s_oow, s_ss} = sync2;

  // switching clock enables, channel one on the opposite half period
  logic [15:0] div_cnt;
  logic        tick_a;
  logic        tick_b;
  tbsfc_chan_t tick;
  always_ff @(posedge aclk) begin
    if (!aresetn || div_cnt == 16'(SW_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign tick_b = (div_cnt == 16'h0000);
  assign tick_a = (div_cnt == 16'(SW_DIV / 2));
  assign tick   = {tick_b, tick_b, tick_a};

  // automatic sequencer
  tbsfc_seq_t  seq;
  logic [1:0]  step;
  logic [1:0]  order_sel;
  logic        order_ok;
  tbsfc_chan_t auto_mask;
  tbsfc_chan_t ch_req;
  tbsfc_chan_t ch_run;
  tbsfc_chan_t hiccup;

  function automatic logic [1:0] ord_f(input logic [1:0] sel,
                                       input logic [1:0] pos);
    logic [1:0] c;
    c = 2'h0;
    case (sel)
      2'h1: c = (pos == 2'h0) ? 2'h1 : (pos == 2'h1) ? 2'h0 : 2'h2;
      2'h2: c = (pos == 2'h0) ? 2'h1 : (pos == 2'h1) ? 2'h2 : 2'h0;
      2'h3: c = (pos == 2'h0) ? 2'h2 : (pos == 2'h1) ? 2'h1 : 2'h0;
      default: c = 2'h0;
    endcase
    return c;
  endfunction

  assign order_sel = {s_en1, s_en2};
  assign order_ok  = (order_sel != 2'h0);   // both low is a reserved setting

  always_comb begin
    auto_mask = '0;
    for (int p = 0; p < 3; p++) begin
      if (2'(p) < step) begin
        auto_mask[ord_f(order_sel, 2'(p))] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || s_ot || s_undervoltage_lockout || !order_ok || !s_mode) begin
      seq  <= TBSFC_SEQ_OFF;
      step <= 2'h0;
    end else begin
      case (seq)
        TBSFC_SEQ_OFF: begin
          if (s_en3) begin
            seq <= TBSFC_SEQ_UP;
          end
        end
        TBSFC_SEQ_UP: begin
          if (!s_en3) begin
            seq <= TBSFC_SEQ_DOWN;
          end else if (step == 2'h3) begin
            seq <= TBSFC_SEQ_ON;
          end else if (step == 2'h0 ||
                       s_pgin[ord_f(order_sel, step - 2'h1)]) begin
            step <= step + 2'h1;
          end
        end
        TBSFC_SEQ_ON: begin
          if (!s_en3) begin
            seq <= TBSFC_SEQ_DOWN;
          end
        end
        TBSFC_SEQ_DOWN: begin
          if (step == 2'h0) begin
            seq <= TBSFC_SEQ_OFF;
          end else if (tick_b) begin
            step <= step - 2'h1;
          end
        end
        default: seq <= TBSFC_SEQ_OFF;
      endcase
    end
  end

  assign ch_req = s_mode ? auto_mask : {s_en3, s_en2, s_en1};
  assign ch_run = ch_req & ~hiccup & {3{!s_ot && !s_undervoltage_lockout}};

  // software controls
  logic                  skip_en;
  logic [`TBSFC_IRQ_W-1:0] irq_stat;
  logic [`TBSFC_IRQ_W-1:0] irq_mask;
  tbsfc_chan_t           hic_trip;
  tbsfc_chan_t           sink_blk;

  // per-channel switching decisions and hiccup timers
  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [8:0]  oc_cnt;
    logic [13:0] hic_cnt;

    always_ff @(posedge aclk) begin
      if (!aresetn || !ch_run[i]) begin
        high_side_on[i] <= 1'b0;
        low_side_on[i]  <= 1'b0;
        sink_blk[i]     <= 1'b0;
      end else if (tick[i]) begin
        sink_blk[i] <= s_sink[i];
        if (s_sink[i]) begin
          high_side_on[i] <= 1'b0;
          low_side_on[i]  <= 1'b0;
        end else if (s_src[i] || s_ov[i] || s_buv[i]) begin
          high_side_on[i] <= 1'b0;
          low_side_on[i]  <= 1'b1;
        end else if (s_peak[i]) begin
          // a still-tripped peak comparator must not get a turn-on pulse
          high_side_on[i] <= 1'b0;
          low_side_on[i]  <= !(skip_en && s_zc[i]);
        end else if (skip_en && s_cl[i]) begin
          high_side_on[i] <= 1'b0;
          low_side_on[i]  <= 1'b0;
        end else begin
          high_side_on[i] <= 1'b1;
          low_side_on[i]  <= 1'b0;
        end
      end else if (s_sink[i] || sink_blk[i]) begin
        high_side_on[i] <= 1'b0;
        low_side_on[i]  <= 1'b0;
        sink_blk[i]     <= 1'b1;
      end else if (s_buv[i]) begin
        high_side_on[i] <= 1'b0;
        low_side_on[i]  <= 1'b1;
      end else if (high_side_on[i] && (s_peak[i] || s_ov[i])) begin
        high_side_on[i] <= 1'b0;
        low_side_on[i]  <= 1'b1;
      end else if (low_side_on[i] && skip_en && s_zc[i]) begin
        low_side_on[i]  <= 1'b0;
      end
    end

    // overload counted per switching cycle; trip on the cycle after the wait
    assign hic_trip[i] = tick[i] && s_ovl[i] && !hiccup[i] &&
                         oc_cnt == 9'(OC_WAIT);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        oc_cnt    <= '0;
        hic_cnt   <= '0;
        hiccup[i] <= 1'b0;
      end else if (hic_trip[i]) begin
        oc_cnt    <= '0;
        hic_cnt   <= 14'(HICCUP - 1);
        hiccup[i] <= 1'b1;
      end else if (tick[i]) begin
        if (hiccup[i]) begin
          if (hic_cnt == 14'h0000) begin
            hiccup[i] <= 1'b0;
          end else begin
            hic_cnt <= hic_cnt - 14'h0001;
          end
        end else if (s_ovl[i]) begin
          oc_cnt <= oc_cnt + 9'h001;
        end else begin
          oc_cnt <= '0;
        end
      end
    end
  end

  // power_ok_output pull-down with hysteresis between the two windows
  logic pg_cause;
  assign pg_cause = (|s_oow) || s_undervoltage_lockout || s_ot || (|s_ss) ||
                    (s_mode ? !s_en3 : !(s_en1 && s_en2 && s_en3));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_ok_oe  <= 1'b1;
      power_ok_out <= 1'b0;
    end else if (pg_cause) begin
      power_ok_oe  <= 1'b1;
    end else if (&s_pgin) begin
      power_ok_oe  <= 1'b0;
    end
  end

  // interrupt events: hiccup entry, thermal stop, lockout, power lost
  logic ot_q, undervoltage_lockout_q, pd_q;
  logic [`TBSFC_IRQ_W-1:0] irq_ev;
  logic irq_clr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ot_q   <= 1'b0;
      undervoltage_lockout_q <= 1'b0;
      pd_q   <= 1'b1;
    end else begin
      ot_q   <= s_ot;
      undervoltage_lockout_q <= s_undervoltage_lockout;
      pd_q   <= power_ok_oe;
    end
  end
  always_comb begin
    irq_ev = '0;
    irq_ev[`TBSFC_IRQ_HICCUP]   = |hic_trip;
    irq_ev[`TBSFC_IRQ_THERMAL]  = s_ot && !ot_q;
    irq_ev[`TBSFC_IRQ_UNDERVOLTAGE_LOCKOUT]     = s_undervoltage_lockout && !undervoltage_lockout_q;
    irq_ev[`TBSFC_IRQ_PWR_LOST] = power_ok_oe && !pd_q;
  end
  // a new event in the clearing cycle survives the read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~{`TBSFC_IRQ_W{irq_clr}}) | irq_ev;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // axi4-lite write path: address and data taken in either order
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TBSFC_RESP_OKAY;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_strb       <= '0;
      skip_en       <= `TBSFC_CTRL_RESET;
      irq_mask      <= `TBSFC_IRQ_MASK_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= `TBSFC_RESP_OKAY;
        if (wr_addr == `TBSFC_ADDR_CTRL) begin
          if (wr_strb[0]) begin
            skip_en <= wr_data[`TBSFC_CTRL_SKIP_BIT];
          end
        end else if (wr_addr == `TBSFC_ADDR_IRQ_MASK) begin
          if (wr_strb[0]) begin
            irq_mask <= wr_data[`TBSFC_IRQ_W-1:0];
          end
        end else if (wr_addr != `TBSFC_ADDR_STATUS &&
                     wr_addr != `TBSFC_ADDR_IRQ_STAT) begin
          s_axi_bresp <= `TBSFC_RESP_SLVERR;
        end
      end
    end
  end

  // axi4-lite read path
  assign irq_clr = s_axi_arvalid && s_axi_arready &&
                   s_axi_araddr == `TBSFC_ADDR_IRQ_STAT;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `TBSFC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `TBSFC_RESP_OKAY;
      s_axi_rdata   <= '0;
      if (s_axi_araddr == `TBSFC_ADDR_CTRL) begin
        s_axi_rdata <= {31'h00000000, skip_en};
      end else if (s_axi_araddr == `TBSFC_ADDR_STATUS) begin
        s_axi_rdata <= {16'h0000, seq, power_ok_oe, s_ot, s_undervoltage_lockout,
                        hiccup, ch_run, 1'b0, step};
      end else if (s_axi_araddr == `TBSFC_ADDR_IRQ_STAT) begin
        s_axi_rdata <= {28'h0000000, irq_stat};
      end else if (s_axi_araddr == `TBSFC_ADDR_IRQ_MASK) begin
        s_axi_rdata <= {28'h0000000, irq_mask};
      end else begin
        s_axi_rresp <= `TBSFC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence boot_low_s;
    s_buv[1] && ch_run[1] && !s_sink[1] && !sink_blk[1];
  endsequence
  sequence recharge_s;
    !high_side_on[1] && low_side_on[1];
  endsequence

  ov_blocks_hs_a: assert property (
    s_ov[1] |=> !high_side_on[1])
    else $error("high side on during overvoltage");
  boot_recharge_a: assert property (
    boot_low_s |=> recharge_s)
    else $error("boot capacitor not recharged");
  peak_cut_a: assert property (
    s_peak[1] |=> !high_side_on[1])
    else $error("high side kept on past peak current");
  sink_both_off_a: assert property (
    s_sink[1] |=> !high_side_on[1] && !low_side_on[1])
    else $error("switch on after sinking limit");
  undervoltage_lockout_all_off_a: assert property (
    s_undervoltage_lockout |=> (high_side_on | low_side_on) == 3'h0)
    else $error("converter on during lockout");
  thermal_stop_a: assert property (
    s_ot |=> high_side_on == 3'h0 && seq == TBSFC_SEQ_OFF)
    else $error("switching during thermal stop");
  pg_outer_a: assert property (
    (s_oow != 3'h0) |=> power_ok_oe)
    else $error("power ok released outside window");
  phase_split_a: assert property (
    $rose(high_side_on[0]) |-> $past(tick_a))
    else $error("channel one turned on outside its own phase");
  manual_off_a: assert property (
    !s_mode && !s_en2 |=> !high_side_on[1] && !low_side_on[1])
    else $error("channel two runs with its enable low");

endmodule

// file: tbsfc_pkg.sv
package tbsfc_pkg;

  typedef logic [2:0] tbsfc_chan_t;

  typedef enum logic [3:0] {
    TBSFC_SEQ_OFF  = 4'h1,
    TBSFC_SEQ_UP   = 4'h2,
    TBSFC_SEQ_ON   = 4'h4,
    TBSFC_SEQ_DOWN = 4'h8
  } tbsfc_seq_t;

endpackage

// file: tbsfc_stage_model.sv
`timescale 1ns/100ps
module tbsfc_stage_model #(
  parameter int SETTLE = 40
) (
  // clock and reset
  input  logic                   aclk,
  input  logic                   aresetn,
  // switch drives from the controller
  input  tbsfc_pkg::tbsfc_chan_t high_side_on,
  input  tbsfc_pkg::tbsfc_chan_t low_side_on,
  // output pushed out of regulation on command
  input  tbsfc_pkg::tbsfc_chan_t drift_out,
  // feedback and soft-start comparators
  output tbsfc_pkg::tbsfc_chan_t feedback_in_window,
  output tbsfc_pkg::tbsfc_chan_t feedback_out_window,
  output tbsfc_pkg::tbsfc_chan_t soft_start_active
);
  import tbsfc_pkg::*;
  int level [3];

  // output charges while its stage switches and sags when idle, so the
  // window opens only some time after a channel starts
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (!aresetn) begin
        level[i] <= 0;
      end else if (high_side_on[i] || low_side_on[i]) begin
        level[i] <= (level[i] < SETTLE) ? level[i] + 1 : SETTLE;
      end else begin
        level[i] <= (level[i] > 0) ? level[i] - 1 : 0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      feedback_in_window[i]  = (level[i] == SETTLE) && !drift_out[i];
      feedback_out_window[i] = (level[i] < SETTLE / 2) || drift_out[i];
      soft_start_active[i]   = (level[i] > 0) && (level[i] < SETTLE);
    end
  end
endmodule
